// ==== src/wdog_consts.vh ====
/*
 constants for the window watchdog: window lengths in oscillator periods,
 trigger filter and power-up reset timing. assumes a 100 MHz system clock.
*/
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH

`define CLK_PERIOD_NS      10
`define LEAD_PERIODS       3922
`define CLOSED_PERIODS     800
`define OPEN_PERIODS       840
`define PULSE_PERIODS      157
`define TRIG_MIN_NS        3000
`define TRIG_MIN_CYCLES    ((`TRIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define POR_TIME_MS        10
`define POR_CYCLES         (`POR_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define OSC_DIV_DEFAULT    1250

`endif

// ==== src/window_watchdog_reset.v ====
/*
 window watchdog with active-low reset output and two trigger inputs.
 assumes inputs synchronous to clock_in; oscillator period is a divider
 of clock_in standing in for the resistor-set internal oscillator.
*/
`timescale 1ns/1ns
`include "wdog_consts.vh"

module window_watchdog_reset #(
    parameter OSC_DIV    = `OSC_DIV_DEFAULT,
    parameter POR_CYCLES = `POR_CYCLES
) (
    input  wire clock_in,
    input  wire rst_n_in,
    input  wire falling_trigger_in,
    input  wire rising_trigger_in,
    input  wire low_power_mode_in,
    input  wire power_up_in,
    input  wire silent_wake_in,
    input  wire debug_select_in,
    output reg  reset_n_out,
    output reg  window_open_out
);

    localparam [5:0] S_POR    = 6'h01;
    localparam [5:0] S_LEAD   = 6'h02;
    localparam [5:0] S_CLOSED = 6'h04;
    localparam [5:0] S_OPEN   = 6'h08;
    localparam [5:0] S_PULSE  = 6'h10;
    localparam [5:0] S_OFF    = 6'h20;
    localparam [11:0] LEAD_N   = `LEAD_PERIODS;
    localparam [11:0] CLOSED_N = `CLOSED_PERIODS;
    localparam [11:0] OPEN_N   = `OPEN_PERIODS;
    localparam [11:0] PULSE_N  = `PULSE_PERIODS;
    localparam [15:0] TRIG_N   = `TRIG_MIN_CYCLES;
    // idle pin level per channel: falling channel idles high, rising idles low
    localparam [1:0]  IDLE_LVL = 2'h1;

    wire [1:0]  trig_pin;
    wire [1:0]  chan_hit;
    wire        trig;
    reg  [31:0] osc_cnt;
    reg         osc_tick;
    reg  [31:0] por_cnt;
    reg  [11:0] win_cnt;
    reg  [5:0]  state;
    reg  [5:0]  next_state;
    reg         load;
    wire        off;

    assign off = low_power_mode_in | debug_select_in;

    assign trig_pin = {rising_trigger_in, falling_trigger_in};

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1)
        begin : g_chan
            reg  [1:0]  sync;
            reg  [15:0] width;
            reg         armed;
            reg         hit;

            // reset to idle level so no false edge follows reset
            always @(posedge clock_in)
            begin
                if (!rst_n_in)
                    sync <= {2{IDLE_LVL[c]}};
                else
                    sync <= {sync[0], trig_pin[c]};
            end

            // idle level arms, held active level past min width fires once
            always @(posedge clock_in)
            begin
                if (!rst_n_in)
                begin
                    width <= 16'h0000;
                    armed <= 1'b0;
                    hit   <= 1'b0;
                end
                else
                begin
                    hit <= 1'b0;
                    if (sync[1] == IDLE_LVL[c])
                    begin
                        width <= 16'h0000;
                        armed <= 1'b1;
                    end
                    else if (armed)
                    begin
                        width <= width + 16'h0001;
                        if (width == TRIG_N)
                        begin
                            hit   <= 1'b1;
                            armed <= 1'b0;
                        end
                    end
                end
            end

            assign chan_hit[c] = hit;
        end
    endgenerate

    // either channel may service the watchdog
    assign trig = |chan_hit;

    always @(posedge clock_in)
    begin
        if (!rst_n_in || load)
        begin
            osc_cnt  <= 32'h00000000;
            osc_tick <= 1'b0;
        end
        else if (osc_cnt == OSC_DIV - 1)
        begin
            osc_cnt  <= 32'h00000000;
            osc_tick <= 1'b1;
        end
        else
        begin
            osc_cnt  <= osc_cnt + 32'h00000001;
            osc_tick <= 1'b0;
        end
    end

    always @*
    begin
        next_state = state;
        load = 1'b0;
        case (state)
            S_POR:
                // hold low for power-up reset time
                if (por_cnt >= POR_CYCLES - 1)
                begin
                    next_state = S_LEAD;
                    load = 1'b1;
                end
            S_LEAD:
                if (trig)
                begin
                    next_state = S_CLOSED;
                    load = 1'b1;
                end
                else if (osc_tick && win_cnt == 12'h001)
                begin
                    next_state = S_PULSE;
                    load = 1'b1;
                end
            S_CLOSED:
                if (trig)
                begin
                    next_state = S_PULSE;
                    load = 1'b1;
                end
                else if (osc_tick && win_cnt == 12'h001)
                begin
                    next_state = S_OPEN;
                    load = 1'b1;
                end
            S_OPEN:
                if (trig)
                begin
                    next_state = S_CLOSED;
                    load = 1'b1;
                end
                else if (osc_tick && win_cnt == 12'h001)
                begin
                    next_state = S_PULSE;
                    load = 1'b1;
                end
            S_PULSE:
                if (osc_tick && win_cnt == 12'h001)
                begin
                    next_state = S_LEAD;
                    load = 1'b1;
                end
            S_OFF:
                next_state = S_OFF;
            default:
            begin
                next_state = S_POR;
                load = 1'b1;
            end
        endcase
        // silent wake level restarts lead window on every cycle it is high, unless off or power_up_in
        if (silent_wake_in && !off)
        begin
            next_state = S_LEAD;
            load = 1'b1;
        end
        // supply ramp or sleep wake starts power-up reset
        if (power_up_in)
        begin
            next_state = S_POR;
            load = 1'b1;
        end
        // off overrides; pre-normal is not off
        if (off)
        begin
            next_state = S_OFF;
            load = (state != S_OFF);
        end
        else if (state == S_OFF)
        begin
            // leaving off re-enters lead, host gets a full lead window
            next_state = S_LEAD;
            load = 1'b1;
        end
    end

    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            state   <= S_POR;
            por_cnt <= 32'h00000000;
            win_cnt <= 12'h000;
        end
        else
        begin
            state   <= next_state;
            por_cnt <= (next_state == S_POR && !load) ? por_cnt + 32'h00000001 : 32'h00000000;
            if (load)
            begin
                case (next_state)
                    S_LEAD:   win_cnt <= LEAD_N;
                    S_CLOSED: win_cnt <= CLOSED_N;
                    S_OPEN:   win_cnt <= OPEN_N;
                    S_PULSE:  win_cnt <= PULSE_N;
                    default:  win_cnt <= 12'h000;
                endcase
            end
            else if (osc_tick && win_cnt != 12'h000)
                win_cnt <= win_cnt - 12'h001;
        end
    end

    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            reset_n_out     <= 1'b0;
            window_open_out <= 1'b0;
        end
        else
        begin
            reset_n_out     <= !(next_state == S_POR || next_state == S_PULSE);
            window_open_out <= (next_state == S_OPEN);
        end
    end

endmodule

// ==== sim/host_model.sv ====
/* host model: drives one trigger input with a pulse of commanded width.
   assumes a new command only after the last pulse has ended. */
`timescale 1ns/1ns
module host_model (
    input  wire        clock_in,
    input  wire        go_in,
    input  wire        rise_in,
    input  wire [15:0] width_in,
    output wire        falling_trigger_out,
    output wire        rising_trigger_out
);
    reg [15:0] left = 16'h0;
    reg        mode = 1'b0;
    always @(posedge clock_in)
    begin
        if (go_in)
        begin
            left <= width_in;
            mode <= rise_in;
        end
        else if (left != 16'h0)
            left <= left - 16'h1;
    end
    assign falling_trigger_out = !(left != 16'h0 && !mode);
    assign rising_trigger_out  = left != 16'h0 && mode;
endmodule

// ==== sim/wdog_props.sv ====
/* assertions on the watchdog ports.
   assumes binding to window_watchdog_reset, one clock domain. */
`timescale 1ns/1ns
module wdog_props (
    input wire clock_in,
    input wire rst_n_in,
    input wire low_power_mode_in,
    input wire debug_select_in,
    input wire reset_n_out,
    input wire window_open_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    in_reset_a: assert property (disable iff (1'b0) !rst_n_in |=> !reset_n_out)
        else $error("reset output high in reset");
    por_low_a: assert property ($rose(rst_n_in) |-> !reset_n_out [*8])
        else $error("power-up reset too short");
    lowpow_off_a: assert property (low_power_mode_in [*2] |-> reset_n_out)
        else $error("reset in low power");
    debug_off_a: assert property (debug_select_in [*2] |-> reset_n_out && !window_open_out)
        else $error("watchdog active in debug");
    lead_first_a: assert property ($rose(reset_n_out) |-> !window_open_out [*8])
        else $error("open window without lead");
    open_span_a: assert property ($rose(window_open_out) |-> window_open_out [*8])
        else $error("open window too short");
    pulse_span_a: assert property ($fell(reset_n_out) |-> !reset_n_out [*8])
        else $error("reset pulse too short");
    reset_shut_a: assert property (!reset_n_out |=> !window_open_out)
        else $error("open window during reset");
endmodule
bind window_watchdog_reset wdog_props i_wdog_props (.clock_in, .rst_n_in, .low_power_mode_in,
    .debug_select_in, .reset_n_out, .window_open_out);

// ==== sim/window_watchdog_reset_test.sv ====
/* bench: host model triggers the watchdog, reset output timed in cycles.
   assumes OSC_DIV 4 and POR_CYCLES 20; tolerance covers up to four ticks. */
`timescale 1ns/1ns
`include "wdog_consts.vh"
module window_watchdog_reset_test;
    localparam POR  = 20;
    localparam LEAD = `LEAD_PERIODS * 4;
    localparam CLS  = `CLOSED_PERIODS * 4;
    localparam OPN  = `OPEN_PERIODS * 4;
    localparam PLS  = `PULSE_PERIODS * 4;
    localparam Q    = `TRIG_MIN_CYCLES + 3;
    reg        clock_in, rst_n_in, go, rise, low_power, power_up, wake, debug;
    reg [15:0] width;
    wire       falling, rising, reset_n, window_open;
    integer    num_errors, checks, n;
    host_model i_host_model (.clock_in(clock_in), .go_in(go), .rise_in(rise), .width_in(width),
        .falling_trigger_out(falling), .rising_trigger_out(rising));
    window_watchdog_reset #(.OSC_DIV(4), .POR_CYCLES(POR)) i_window_watchdog_reset (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .falling_trigger_in(falling),
        .rising_trigger_in(rising), .low_power_mode_in(low_power), .power_up_in(power_up),
        .silent_wake_in(wake), .debug_select_in(debug), .reset_n_out(reset_n),
        .window_open_out(window_open));
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = !clock_in;
    end
    task automatic test_done;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic near(input integer got, input integer want, input integer tol);
        checks = checks + 1;
        if (got < want - tol || got > want + tol)
        begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: %0d, not %0d", $time, got, want);
        end
    endtask
    // bounded wait for an output level, n counts edges
    task automatic wait_for(input s, input v, input integer lim);
        n = 0;
        while ((s ? window_open : reset_n) !== v)
        begin
            @(posedge clock_in);
            #1;
            n = n + 1;
            if (n > lim)
            begin
                near(n, lim, 0);
                test_done;
            end
        end
    endtask
    task automatic trig(input r, input [15:0] w);
        @(posedge clock_in);
        go <= 1'b1;
        rise <= r;
        width <= w;
        @(posedge clock_in);
        go <= 1'b0;
    endtask
    task automatic t_lead;
        wait_for(0, 1, POR + 9);
        near(n, POR, 3);
        wait_for(0, 0, LEAD + 50);
        near(n, LEAD, 12);
        wait_for(0, 1, PLS + 50);
        near(n, PLS, 12);
    endtask
    task automatic t_windows;
        trig(0, 16'h0190);
        wait_for(1, 1, Q + CLS + 99);
        near(n, Q + CLS, 16);
        repeat (1000) @(posedge clock_in);
        trig(1, 16'h0190);
        wait_for(1, 0, Q + 99);
        near(n, Q, 16);
        near(reset_n === 1'b1, 1, 0);
        repeat (100) @(posedge clock_in);
        trig(0, 16'h00C8);
        wait_for(1, 1, CLS + 99);
        near(n, CLS - 100, 16);
        wait_for(0, 0, OPN + 50);
        near(n, OPN, 12);
        wait_for(0, 1, PLS + 50);
    endtask
    task automatic t_early;
        trig(0, 16'h0190);
        repeat (1500) @(posedge clock_in);
        trig(1, 16'h0190);
        wait_for(0, 0, Q + 99);
        near(n, Q, 16);
        wait_for(0, 1, PLS + 50);
        near(n, PLS, 12);
    endtask
    task automatic t_off;
        fork
            wait_for(0, 0, LEAD + 4099);
            begin
                @(posedge clock_in);
                low_power <= 1'b1;
                repeat (2000) @(posedge clock_in);
                low_power <= 1'b0;
                debug <= 1'b1;
                repeat (2000) @(posedge clock_in);
                debug <= 1'b0;
            end
        join
        near(n, LEAD + 4000, 16);
        wait_for(0, 1, PLS + 50);
    endtask
    task automatic t_wake;
        repeat (3000) @(posedge clock_in);
        wake <= 1'b1;
        @(posedge clock_in);
        wake <= 1'b0;
        wait_for(0, 0, LEAD + 50);
        near(n, LEAD, 12);
        wait_for(0, 1, PLS + 50);
        @(posedge clock_in);
        power_up <= 1'b1;
        @(posedge clock_in);
        power_up <= 1'b0;
        wait_for(0, 0, 5);
        wait_for(0, 1, POR + 9);
        near(n, POR, 4);
    endtask
    initial
    begin
        {rst_n_in, go, rise, low_power, power_up, wake, debug} = 7'h0;
        width = 16'h0;
        num_errors = 0;
        checks = 0;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        t_lead;
        t_windows;
        t_early;
        t_off;
        t_wake;
        test_done;
    end
endmodule
